// ### dv/mac_err_src.sv
// receive datapath stand-in: one-cycle fifo error pulses on request
`timescale 1ns/1ps
module mac_err_src (
    input  wire logic pclk, presetn, ovf_req, unf_req,
    output logic      rx_fifo_overflow, rx_fifo_underflow
);
    logic ovf_q, unf_q;  // last request levels
    // pulse only on a fresh request, as the real fifo flags do
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) {ovf_q, unf_q, rx_fifo_overflow, rx_fifo_underflow} <= 4'h0;
        else begin
            {ovf_q, unf_q} <= {ovf_req, unf_req};
            rx_fifo_overflow  <= ovf_req & ~ovf_q;
            rx_fifo_underflow <= unf_req & ~unf_q;
        end
    end
endmodule // mac_err_src

// ### dv/mac_if_chk.sv
// port-level assertions for the mac interface control block
`timescale 1ns/1ps
`include "mac_if_cfg.svh"
module mac_if_chk import mac_if_pkg::*; (
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready, pslverr, rx_fifo_overflow, rx_fifo_underflow,
    input wire logic        rmii_enable, tx_clk_shift_en, crs_dv_hold, irq,
    input ref_clk_t         ref_clk_sel,
    input eb_size_t         eb_size,
    input wire logic [4:0]  eb_tolerance_bits
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // reference of the low-active flags: an event sets, a control read setup clears, event wins
    logic ovf_seen_q;
    logic unf_seen_q;
    logic ctrl_setup;
    assign ctrl_setup = psel && !penable && !pwrite && (paddr == `ADDR_CTRL);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_seen_q <= 1'b1;
            unf_seen_q <= 1'b1;
        end else begin
            ovf_seen_q <= rx_fifo_overflow || (ovf_seen_q && !ctrl_setup);
            unf_seen_q <= rx_fifo_underflow || (unf_seen_q && !ctrl_setup);
        end
    end
    // bus steps
    sequence ctrl_wr; psel && penable && pwrite && paddr == `ADDR_CTRL && pstrb == 4'h3; endsequence
    sequence ctrl_rd_setup; psel && !penable && !pwrite && paddr == `ADDR_CTRL; endsequence
    a_pready_high: assert property (pready) else $error("pready low");
    a_slverr_unmapped: assert property (psel && penable && paddr > `ADDR_IRQ_MASK |-> pslverr) else $error("no slverr");
    a_shift_gate: assert property (tx_clk_shift_en |-> rmii_enable && ref_clk_sel == REF_50MHZ) else $error("shift");
    a_tol_decode: assert property (eb_tolerance_bits == (eb_size == EB_14BIT ? 5'h0E : eb_size == EB_2BIT ? 5'h02 :
        eb_size == EB_6BIT ? 5'h06 : 5'h0A)) else $error("tolerance");
    a_ovf_reads_low: assert property (ctrl_rd_setup |=> prdata[3] == !$past(ovf_seen_q)) else $error("ovf");
    a_unf_reads_low: assert property (ctrl_rd_setup |=> prdata[2] == !$past(unf_seen_q)) else $error("unf");
    a_cfg_write: assert property (ctrl_wr |=> rmii_enable == $past(pwdata[5]) && crs_dv_hold == $past(pwdata[4])
        && ref_clk_sel == $past(pwdata[7]) && eb_size == $past(pwdata[1:0])) else $error("cfg");
    a_shift_write: assert property (ctrl_wr |=> tx_clk_shift_en == $past(pwdata[8] & pwdata[7] & pwdata[5]))
        else $error("shift write");
    a_rsvd_zero: assert property (ctrl_rd_setup |=> prdata[31:9] == 23'h0) else $error("reserved");
    a_irq_cause: assert property ($rose(irq) |-> $past(rx_fifo_overflow || rx_fifo_underflow || psel)) else $error("irq");
endmodule // mac_if_chk
bind mac_if_ctrl mac_if_chk chk_u (.*);

// ### dv/mac_interface_control_register_test.sv
// self-checking bench for the mac interface control block
`timescale 1ns/1ps
`include "mac_if_cfg.svh"
module mac_interface_control_register_test;
    import mac_if_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ovf_req = 0, unf_req = 0;
    logic strap_rmii_mode = 0, strap_clk_sel = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, w;
    logic [3:0]  pstrb = 0;
    wire  [31:0] prdata;
    wire  [4:0]  eb_tolerance_bits;
    wire  pready, pslverr, rx_fifo_overflow, rx_fifo_underflow, rmii_enable, tx_clk_shift_en, crs_dv_hold, irq;
    ref_clk_t ref_clk_sel;
    eb_size_t eb_size;
    int error_cnt = 0, compares = 0, seed = 76878;
    mac_if_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .strap_rmii_mode, .strap_clk_sel, .rx_fifo_overflow, .rx_fifo_underflow, .rmii_enable,
        .ref_clk_sel, .tx_clk_shift_en, .crs_dv_hold, .eb_size, .eb_tolerance_bits, .irq);
    mac_err_src src_u (.pclk, .presetn, .ovf_req, .unf_req, .rx_fifo_overflow, .rx_fifo_underflow);
    initial forever #5 pclk = ~pclk;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task apb(input [11:0] a, input wr, input [31:0] d, input [3:0] s);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, wr, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle budget here, only the watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // expected word: reserved zero, bit6 as written, both flags high
    function logic [31:0] exp_ctrl(input logic [31:0] d);
        return (d & 32'h000001F3) | 32'h0000000C;
    endfunction
    function logic [4:0] exp_tol(input logic [1:0] c);
        return c == 2'h0 ? 5'h0E : c == 2'h1 ? 5'h02 : c == 2'h2 ? 5'h06 : 5'h0A;
    endfunction
    task wrap_up;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        {strap_rmii_mode, strap_clk_sel} <= 2'($random(seed));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(`ADDR_CTRL, 0, 0, 0);
        chk("reset word", {strap_clk_sel, 1'b1, strap_rmii_mode, 5'h01}, rd);
        for (int i = 0; i < 8; i++) begin
            w = ($random(seed) & 32'hFFFFFFFC) | 32'h40 | i[1:0];
            apb(`ADDR_CTRL, 1, w, 4'h3);
            apb(`ADDR_CTRL, 0, 0, 0);
            chk("ctrl word", exp_ctrl(w), rd);
            chk("rmii", w[5], rmii_enable);
            chk("refclk", w[7], ref_clk_sel);
            chk("hold", w[4], crs_dv_hold);
            chk("shift", w[8] & w[7] & w[5], tx_clk_shift_en);
            // settings sized for half packet lengths by the host
            chk("tol", exp_tol(w[1:0]), eb_tolerance_bits);
            chk("eb size", w[1:0], eb_size);
        end
        apb(`ADDR_IRQ_MASK, 1, 32'h1, 4'h1);
        ovf_req <= 1'b1;
        unf_req <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("irq on", 1, irq);
        apb(`ADDR_CTRL, 0, 0, 0);
        chk("flags low", exp_ctrl(w) & 32'hFFFFFFF3, rd);
        apb(`ADDR_CTRL, 0, 0, 0);
        chk("flags back", exp_ctrl(w), rd);
        apb(`ADDR_IRQ_STATUS, 0, 0, 0);
        chk("status", 32'h3, rd);
        apb(`ADDR_IRQ_STATUS, 1, 32'h1, 4'h1);
        repeat (2) @(posedge pclk);
        chk("irq masked", 0, irq);
        apb(`ADDR_IRQ_MASK, 1, 32'h2, 4'h1);
        repeat (2) @(posedge pclk);
        chk("irq unf", 1, irq);
        apb(`ADDR_IRQ_STATUS, 1, 32'h2, 4'h1);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 0, irq);
        apb(12'h00C, 0, 0, 0);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, rd);
        apb(`ADDR_CTRL, 1, 32'hFFFFFE00 | w, 4'h3);
        apb(`ADDR_CTRL, 0, 0, 0);
        chk("ro bits", exp_ctrl(w), rd);
        wrap_up();
    end
endmodule // mac_interface_control_register_test

// ### shared/mac_if_cfg.svh
// register layout, reset values and field positions of the mac interface control/status block
`ifndef MAC_IF_CFG_SVH
`define MAC_IF_CFG_SVH
// apb byte addresses (word aligned)
`define ADDR_CTRL        12'h000
`define ADDR_IRQ_STATUS  12'h004
`define ADDR_IRQ_MASK    12'h008
// field positions of the control/status word
`define BIT_TX_SHIFT     8
`define BIT_CLK_SEL      7
`define BIT_RSVD6        6
`define BIT_RMII_MODE    5
`define BIT_REV_SEL      4
`define BIT_OVF_N        3
`define BIT_UNF_N        2
`define BIT_EB_LSB       0
// reset values
`define RST_RSVD6        1'b1
`define RST_EB_SIZE      2'h1
`define RST_TX_SHIFT     1'b0
`define RST_REV_SEL      1'b0
`define RST_CLK_SEL      1'b0
`define RST_RMII         1'b0
// both fifo flags come up reading "detected" until the first read of the word
`define RST_OVF_N        1'b0
`define RST_UNF_N        1'b0
// elasticity tolerance in bits for each size code
`define EB_TOL_CODE0     5'h0E
`define EB_TOL_CODE1     5'h02
`define EB_TOL_CODE2     5'h06
`define EB_TOL_CODE3     5'h0A
// interrupt bit positions
`define IRQ_OVF          0
`define IRQ_UNF          1
`endif

// ### shared/mac_if_pkg.sv
// types shared by the mac interface control block
package mac_if_pkg;
    // size code of the receive elasticity buffer
    typedef enum logic [1:0] {
        EB_14BIT = 2'b00,
        EB_2BIT  = 2'b01,
        EB_6BIT  = 2'b10,
        EB_10BIT = 2'b11
    } eb_size_t;
    // rmii reference clock choice
    typedef enum logic {
        REF_25MHZ = 1'b0,
        REF_50MHZ = 1'b1
    } ref_clk_t;
endpackage

// ### verilog/mac_if_ctrl.sv
// mac interface control/status register with apb slave, strap capture and fifo error flags
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "mac_if_cfg.svh"
module mac_if_ctrl (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // bootstrap pins, sampled after reset release
    input  wire logic                  strap_rmii_mode,
    input  wire logic                  strap_clk_sel,
    // fifo error pulses from the receive datapath (pclk domain)
    input  wire logic                  rx_fifo_overflow,
    input  wire logic                  rx_fifo_underflow,
    // configuration towards the mac interface logic
    output logic                       rmii_enable,
    output mac_if_pkg::ref_clk_t       ref_clk_sel,
    output logic                       tx_clk_shift_en,
    output logic                       crs_dv_hold,
    output mac_if_pkg::eb_size_t       eb_size,
    output logic      [4:0]            eb_tolerance_bits,
    // interrupt
    output logic                       irq
);
    import mac_if_pkg::*;

    // synchronised strap levels
    logic [1:0] strap_sync;
    mac_if_sync #(
        .WIDTH    (2)
    ) u_strap_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({strap_clk_sel, strap_rmii_mode}),
        .sync_out (strap_sync)
    );

    // control state
    logic       tx_shift_q,  tx_shift_d;    // clock shift enable
    logic       clk_sel_q,   clk_sel_d;     // reference clock select
    logic       rsvd6_q,     rsvd6_d;       // reserved r/w bit
    logic       rmii_q,      rmii_d;        // interface select
    logic       rev_q,       rev_d;         // crs_dv revision behaviour
    logic [1:0] eb_q,        eb_d;          // elasticity size code
    logic       ovf_n_q,     ovf_n_d;       // overflow flag, low active
    logic       unf_n_q,     unf_n_d;       // underflow flag, low active
    logic [1:0] strap_cnt_q, strap_cnt_d;   // waits for synchroniser to fill
    logic       strap_done_q, strap_done_d; // straps already latched
    logic [1:0] ist_q,       ist_d;         // sticky interrupt status
    logic [1:0] imask_q,     imask_d;       // interrupt mask
    logic [31:0] rdata_q,    rdata_d;       // registered read data

    // apb decode, zero wait state
    logic wr_en;
    logic rd_en;
    logic hit_ctrl, hit_ist, hit_imask;
    assign wr_en     = psel && penable && pwrite;
    assign rd_en     = psel && !penable && !pwrite;
    assign hit_ctrl  = (paddr == `ADDR_CTRL);
    assign hit_ist   = (paddr == `ADDR_IRQ_STATUS);
    assign hit_imask = (paddr == `ADDR_IRQ_MASK);
    assign pready    = 1'b1;
    // unmapped addresses answer with an error, no state change
    assign pslverr   = psel && penable && !(hit_ctrl || hit_ist || hit_imask);

    // the visible 16-bit control/status word
    logic [15:0] ctrl_word;
    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[`BIT_TX_SHIFT]  = tx_shift_q;
        ctrl_word[`BIT_CLK_SEL]   = clk_sel_q;
        ctrl_word[`BIT_RSVD6]     = rsvd6_q;
        ctrl_word[`BIT_RMII_MODE] = rmii_q;
        ctrl_word[`BIT_REV_SEL]   = rev_q;
        ctrl_word[`BIT_OVF_N]     = ovf_n_q;
        ctrl_word[`BIT_UNF_N]     = unf_n_q;
        ctrl_word[`BIT_EB_LSB +: 2] = eb_q;
    end

    // next-state logic for all registers
    always_comb begin
        tx_shift_d   = tx_shift_q;
        clk_sel_d    = clk_sel_q;
        rsvd6_d      = rsvd6_q;
        rmii_d       = rmii_q;
        rev_d        = rev_q;
        eb_d         = eb_q;
        ovf_n_d      = ovf_n_q;
        unf_n_d      = unf_n_q;
        strap_cnt_d  = strap_cnt_q;
        strap_done_d = strap_done_q;
        ist_d        = ist_q;
        imask_d      = imask_q;
        rdata_d      = rdata_q;
        // straps latched once, after both sync stages hold pin levels
        if (!strap_done_q) begin
            if (strap_cnt_q == 2'h2) begin
                rmii_d       = strap_sync[0];
                clk_sel_d    = strap_sync[1];
                strap_done_d = 1'b1;
            end else begin
                strap_cnt_d = strap_cnt_q + 2'h1;
            end
        end
        // software writes, low byte lanes only matter
        if (wr_en && hit_ctrl) begin
            if (pstrb[1]) begin
                tx_shift_d = pwdata[`BIT_TX_SHIFT];
            end
            if (pstrb[0]) begin
                clk_sel_d = pwdata[`BIT_CLK_SEL];
                rsvd6_d   = pwdata[`BIT_RSVD6];
                rmii_d    = pwdata[`BIT_RMII_MODE];
                rev_d     = pwdata[`BIT_REV_SEL];
                eb_d      = pwdata[`BIT_EB_LSB +: 2];
            end
        end
        if (wr_en && hit_imask && pstrb[0]) begin
            imask_d = pwdata[1:0];
        end
        // write one to clear, set wins below
        if (wr_en && hit_ist && pstrb[0]) begin
            ist_d = ist_q & ~pwdata[1:0];
        end
        // reading the control word restores the normal status
        if (rd_en && hit_ctrl) begin
            ovf_n_d = 1'b1;
            unf_n_d = 1'b1;
        end
        if (rx_fifo_overflow) begin
            ovf_n_d          = 1'b0;
            ist_d[`IRQ_OVF]  = 1'b1;
        end
        if (rx_fifo_underflow) begin
            unf_n_d          = 1'b0;
            ist_d[`IRQ_UNF]  = 1'b1;
        end
        // read data captured in setup phase
        if (rd_en) begin
            if (hit_ctrl) begin
                rdata_d = {16'h0000, ctrl_word};
            end else if (hit_ist) begin
                rdata_d = {30'h0, ist_q};
            end else if (hit_imask) begin
                rdata_d = {30'h0, imask_q};
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    // register everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_shift_q   <= `RST_TX_SHIFT;
            clk_sel_q    <= `RST_CLK_SEL;
            rsvd6_q      <= `RST_RSVD6;
            rmii_q       <= `RST_RMII;
            rev_q        <= `RST_REV_SEL;
            eb_q         <= `RST_EB_SIZE;
            // flags start low, software reads once to arm them
            ovf_n_q      <= `RST_OVF_N;
            unf_n_q      <= `RST_UNF_N;
            strap_cnt_q  <= 2'h0;
            strap_done_q <= 1'b0;
            ist_q        <= 2'h0;
            imask_q      <= 2'h0;
            rdata_q      <= 32'h0000_0000;
        end else begin
            tx_shift_q   <= tx_shift_d;
            clk_sel_q    <= clk_sel_d;
            rsvd6_q      <= rsvd6_d;
            rmii_q       <= rmii_d;
            rev_q        <= rev_d;
            eb_q         <= eb_d;
            ovf_n_q      <= ovf_n_d;
            unf_n_q      <= unf_n_d;
            strap_cnt_q  <= strap_cnt_d;
            strap_done_q <= strap_done_d;
            ist_q        <= ist_d;
            imask_q      <= imask_d;
            rdata_q      <= rdata_d;
        end
    end

    // configuration outputs from flip-flops, tx_clk_shift_en gated by rmii and 50 MHz select
    assign prdata      = rdata_q;
    assign rmii_enable = rmii_q;
    assign ref_clk_sel = ref_clk_t'(clk_sel_q);
    assign tx_clk_shift_en = tx_shift_q && rmii_q && (clk_sel_q == REF_50MHZ);
    assign crs_dv_hold = rev_q;
    assign eb_size     = eb_size_t'(eb_q);

    always_comb begin
        unique case (eb_size_t'(eb_q))
            EB_14BIT: eb_tolerance_bits = `EB_TOL_CODE0;
            EB_2BIT:  eb_tolerance_bits = `EB_TOL_CODE1;
            EB_6BIT:  eb_tolerance_bits = `EB_TOL_CODE2;
            EB_10BIT: eb_tolerance_bits = `EB_TOL_CODE3;
        endcase
    end

    // level interrupt from unmasked sticky bits
    assign irq = |(ist_q & imask_q);
endmodule // mac_if_ctrl

// ### verilog/mac_if_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module mac_if_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // levels in and out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;   // first stage, read only by second
    logic [WIDTH-1:0] sync_q;   // second stage
    // plain two-stage capture, constants under reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule // mac_if_sync
